// [shared/ptv_pkg.sv]
// Constants, timing figures and the vote function for the trip voting block.
// Assumes a single 250 MHz system clock.
package ptv_pkg;

    // =========================================================
    // Structure
    localparam int unsigned NUM_CH  = 4;      // Sensor channels
    localparam int unsigned NUM_DIV = 4;      // Division trip logics
    localparam int unsigned NUM_MAN = 2;      // Manual scram divisions
    localparam logic [2:0]  VOTE_MIN = 3'h2;  // Coincidence needed

    // =========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned NS_PER_MS      = 1000000;
    localparam int unsigned MS_PER_S       = 1000;
    localparam int unsigned TICK_PERIOD_MS = 1;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned HOLD_DELAY_S   = 10;   // Mode bypass and reset inhibit
    localparam int unsigned HOLD_TICKS     = HOLD_DELAY_S * MS_PER_S / TICK_PERIOD_MS;

    // =========================================================
    // Synchroniser reset levels
    localparam logic SYNC_IDLE_LOW_TRIP = 1'b1;  // Active-low trip lines idle high
    localparam logic SYNC_IDLE_HIGH     = 1'b0;  // Active-high lines idle low

    // True when at least VOTE_MIN of the bits are set
    function automatic logic ptv_vote(input logic [NUM_CH-1:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            n = n + {2'h0, v[i]};
        end
        return (n >= VOTE_MIN);
    endfunction

endpackage

// [core/ptv_sync.sv]
// Two-flop synchroniser for a vector of switch and trip lines.
// Assumes the inputs may change at any time relative to the clock.
module ptv_sync #(
    parameter int unsigned WIDTH   = 1,
    parameter logic        RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_q;

    // =========================================================
    // Two stages; only the second reads the first
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_q <= {WIDTH{RST_VAL}};
            q_o    <= {WIDTH{RST_VAL}};
        end
        else
        begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule // ptv_sync

// [core/ptv_delay_timer.sv]
// Tick-driven delay timer: runs a fixed number of timebase ticks after start.
// Assumes tick_i is a one-cycle pulse from a free-running prescaler.
module ptv_delay_timer
    import ptv_pkg::*;
#(
    parameter int unsigned TICKS = HOLD_TICKS
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // Control
    input  wire logic tick_i,
    input  wire logic start_i,
    input  wire logic clear_i,
    // Status
    output logic      busy_o,
    output logic      expired_o
);

    localparam int unsigned  CW   = $clog2(TICKS + 1);
    localparam logic [CW-1:0] LOAD = CW'(TICKS);
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [CW-1:0] cnt_q;

    // =========================================================
    // Countdown; expiry sticks until the next start or clear
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q     <= '0;
            busy_o    <= 1'b0;
            expired_o <= 1'b0;
        end
        else if (clear_i)
        begin
            cnt_q     <= '0;
            busy_o    <= 1'b0;
            expired_o <= 1'b0;
        end
        else if (start_i)
        begin
            cnt_q     <= LOAD;
            busy_o    <= 1'b1;
            expired_o <= 1'b0;
        end
        else if (tick_i && busy_o)
        begin
            cnt_q <= cnt_q - ONE;
            if (cnt_q == ONE)
            begin
                busy_o    <= 1'b0;
                expired_o <= 1'b1;
            end
        end
    end

endmodule // ptv_delay_timer

// [core/ptv_trip_voter.sv]
// Four-division trip voting, seal-in, bypass, scram and reset logic.
// Assumes discrete trip lines from channel comparators, neutron divisions and
// operator switches; all asynchronous, synchronised here. One 250 MHz clock.
//
// Overview of operation
// - Each division latches a trip when two or more channels show one condition.
// - Scram when two or more divisions tripped; no bypass at scram level.
// - Channel keylock bypass masks that channel, leaving two of three voting.
// - A bypass request is refused if another channel is already bypassed.
// - High vessel pressure trips on two unbypassed channels; never bypassable.
// - Low water level trips on two unbypassed channels; never bypassable.
// - High drywell pressure trips on two unbypassed channels; never bypassable.
// - Steam line radiation trips on two unbypassed channels; never bypassable.
// - Seismic trips when any of three accelerations high in two channels.
// - Both armed pushbuttons pressed, or mode shutdown, give latched full scram.
// - One armed pushbutton gives latched half scram of its load division.
// - Mode shutdown scram input is bypassed after a ten second delay.
// - Division manual trip latches, same effect as an automatic division trip.
// - Reset switch clears manual latches unless a pushbutton is still pressed.
// - Division reset clears its latch only once the trip cause has gone.
// - Division reset immediate after single trip, blocked ten seconds after scram.
// - Division reset needs charging pressure bypassed and other trips clear.
// - Source range trip is one combined signal per neutron division.
// - Power range trip is one combined signal per neutron division.
// - Control valve fast closure from solenoid closure or low trip oil.
// - First stage pressure bypasses stop and control valve closure trips.
// - Each channel takes inboard and outboard valve positions of one line.
// - Trip lines active low, bypass lines active high; loss forces trip.
module ptv_trip_voter
    import ptv_pkg::*;
#(
    parameter int unsigned TICK_CNT  = TICK_CYCLES,
    parameter int unsigned HOLD_CNT  = HOLD_TICKS
) (
    // Clock and reset
    input  wire logic               sys_clk_i,
    input  wire logic               rst_b_i,
    // Channel comparator trips, active low, one bit per channel
    input  wire logic [NUM_CH-1:0]  press_hi_n_i,
    input  wire logic [NUM_CH-1:0]  level_lo_n_i,
    input  wire logic [NUM_CH-1:0]  drywell_hi_n_i,
    input  wire logic [NUM_CH-1:0]  radiation_hi_n_i,
    input  wire logic [NUM_CH-1:0]  seis_bot_hor_n_i,
    input  wire logic [NUM_CH-1:0]  seis_bot_ver_n_i,
    input  wire logic [NUM_CH-1:0]  seis_top_hor_n_i,
    input  wire logic [NUM_CH-1:0]  stop_valve_n_i,
    input  wire logic [NUM_CH-1:0]  fast_solenoid_n_i,
    input  wire logic [NUM_CH-1:0]  trip_oil_lo_n_i,
    input  wire logic [NUM_CH-1:0]  charging_lo_n_i,
    input  wire logic [NUM_CH-1:0]  iso_inboard_n_i,
    input  wire logic [NUM_CH-1:0]  iso_outboard_n_i,
    // Turbine first stage pressure bypass permissive, active high
    input  wire logic [NUM_CH-1:0]  first_stage_byp_i,
    // Neutron flux monitoring trips, active low, one bit per division
    input  wire logic [NUM_DIV-1:0] source_range_trip_n_i,
    input  wire logic [NUM_DIV-1:0] power_range_trip_n_i,
    // Bypass switches, active high
    input  wire logic [NUM_CH-1:0]  chan_bypass_req_i,
    input  wire logic [NUM_DIV-1:0] charging_bypass_i,
    // Manual controls
    input  wire logic [NUM_MAN-1:0] man_armed_i,
    input  wire logic [NUM_MAN-1:0] man_press_n_i,
    input  wire logic               mode_shutdown_n_i,
    input  wire logic [NUM_DIV-1:0] div_man_trip_n_i,
    input  wire logic               man_reset_i,
    input  wire logic [NUM_DIV-1:0] div_reset_i,
    // Actuator drives, active low
    output logic [NUM_DIV-1:0]      div_trip_n_o,
    output logic [NUM_MAN-1:0]      load_div_trip_n_o,
    output logic                    scram_n_o,
    // Status
    output logic [NUM_CH-1:0]       chan_bypassed_o,
    output logic                    reset_inhibit_o,
    output logic                    mode_bypassed_o
);

    localparam int unsigned NLOW  = 13 * NUM_CH + 3 * NUM_DIV + NUM_MAN + 1;
    localparam int unsigned NHIGH = 2 * NUM_CH + 2 * NUM_DIV + NUM_MAN + 1;
    localparam int unsigned TW    = $clog2(TICK_CNT);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CNT - 1);
    localparam logic [TW-1:0] TICK_ONE  = TW'(1);

    // =========================================================
    // Reset release
    logic [1:0] rst_sync_q;
    logic       rst_b;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_b = rst_sync_q[1];

    // =========================================================
    // Input synchronisers
    logic [NUM_CH-1:0]  s_press, s_level, s_dw, s_rad, s_sbh, s_sbv, s_sth;
    logic [NUM_CH-1:0]  s_stop, s_sol, s_oil, s_chg, s_inb, s_outb;
    logic [NUM_DIV-1:0] s_src, s_pwr, s_dman, s_chgbyp, s_dreset;
    logic [NUM_CH-1:0]  s_fsb, s_bypreq;
    logic [NUM_MAN-1:0] s_press_pb, s_armed;
    logic               s_mode, s_mreset;

    // Active-low trip lines idle in the untripped state
    ptv_sync #(.WIDTH(NLOW), .RST_VAL(SYNC_IDLE_LOW_TRIP)) u_sync_low (
        .clk_i   (sys_clk_i),
        .rst_b_i (rst_b),
        .d_i     ({press_hi_n_i, level_lo_n_i, drywell_hi_n_i, radiation_hi_n_i,
                   seis_bot_hor_n_i, seis_bot_ver_n_i, seis_top_hor_n_i,
                   stop_valve_n_i, fast_solenoid_n_i, trip_oil_lo_n_i,
                   charging_lo_n_i, iso_inboard_n_i, iso_outboard_n_i,
                   source_range_trip_n_i, power_range_trip_n_i,
                   div_man_trip_n_i, man_press_n_i, mode_shutdown_n_i}),
        .q_o     ({s_press, s_level, s_dw, s_rad, s_sbh, s_sbv, s_sth,
                   s_stop, s_sol, s_oil, s_chg, s_inb, s_outb,
                   s_src, s_pwr, s_dman, s_press_pb, s_mode})
    );

    ptv_sync #(.WIDTH(NHIGH), .RST_VAL(SYNC_IDLE_HIGH)) u_sync_high (
        .clk_i   (sys_clk_i),
        .rst_b_i (rst_b),
        .d_i     ({first_stage_byp_i, chan_bypass_req_i, charging_bypass_i,
                   man_armed_i, man_reset_i, div_reset_i}),
        .q_o     ({s_fsb, s_bypreq, s_chgbyp, s_armed, s_mreset, s_dreset})
    );

    // =========================================================
    // Timebase tick prescaler
    logic [TW-1:0] tick_cnt_q;
    logic          tick_q;

    always_ff @(posedge sys_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end
        else
        begin
            tick_q     <= (tick_cnt_q == TICK_LAST);
            tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + TICK_ONE;
        end
    end

    // =========================================================
    // Channel bypass with cross-division interlock
    logic [NUM_CH-1:0] bypass_q;
    logic [NUM_CH-1:0] bypass_d;
    logic              none_bypassed;

    assign none_bypassed = (bypass_q == '0);

    // Keep held bypasses; grant a new one only when none stand, lowest first
    always_comb
    begin
        logic granted;
        granted  = 1'b0;
        bypass_d = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (s_bypreq[i] && bypass_q[i])
            begin
                bypass_d[i] = 1'b1;
            end
            else if (s_bypreq[i] && none_bypassed && !granted)
            begin
                bypass_d[i] = 1'b1;
                granted     = 1'b1;
            end
        end
    end

    // =========================================================
    // Per-channel trip conditions, active high internally
    logic [NUM_CH-1:0] c_press, c_level, c_dw, c_rad, c_seis;
    logic [NUM_CH-1:0] c_stop, c_cvfc, c_iso, c_chg;

    assign c_press = ~s_press & ~bypass_q;
    assign c_level = ~s_level & ~bypass_q;
    assign c_dw    = ~s_dw & ~bypass_q;
    assign c_rad   = ~s_rad & ~bypass_q;
    assign c_seis  = (~s_sbh | ~s_sbv | ~s_sth) & ~bypass_q;
    assign c_stop  = ~s_stop & ~s_fsb & ~bypass_q;
    assign c_cvfc  = (~s_sol | ~s_oil) & ~s_fsb & ~bypass_q;
    assign c_iso   = (~s_inb | ~s_outb) & ~bypass_q;
    assign c_chg   = ~s_chg & ~bypass_q;

    // =========================================================
    // Coincidence votes shared by every division
    logic v_press, v_level, v_dw, v_rad, v_seis, v_stop, v_cvfc, v_iso, v_chg;
    logic v_src, v_pwr, v_common;

    assign v_press  = ptv_vote(c_press);
    assign v_level  = ptv_vote(c_level);
    assign v_dw     = ptv_vote(c_dw);
    assign v_rad    = ptv_vote(c_rad);
    assign v_seis   = ptv_vote(c_seis);
    assign v_stop   = ptv_vote(c_stop);
    assign v_cvfc   = ptv_vote(c_cvfc);
    assign v_iso    = ptv_vote(c_iso);
    assign v_chg    = ptv_vote(c_chg);
    assign v_src    = ptv_vote(~s_src);
    assign v_pwr    = ptv_vote(~s_pwr);
    assign v_common = v_press | v_level | v_dw | v_rad | v_seis | v_stop
                    | v_cvfc | v_iso | v_src | v_pwr;

    // =========================================================
    // Division trip seal-in with reset
    logic [NUM_DIV-1:0] div_cond;
    logic [NUM_DIV-1:0] div_trip_q;
    logic [NUM_DIV-1:0] div_trip_d;
    logic               inhibit_busy;

    // Charging pressure trip stays until bypassed in that division
    assign div_cond   = {NUM_DIV{v_common}} | ({NUM_DIV{v_chg}} & ~s_chgbyp)
                      | ~s_dman;
    // Set wins; reset only with cause gone and no inhibit running
    assign div_trip_d = div_cond
                      | (div_trip_q & ~(s_dreset & {NUM_DIV{~inhibit_busy}}));

    // =========================================================
    // Manual scram latches and mode switch
    logic [NUM_MAN-1:0] man_q;
    logic [NUM_MAN-1:0] man_d;
    logic               mode_q;
    logic               mode_d;
    logic               mode_sd;
    logic               mode_sd_q;
    logic               mode_expired;
    logic               man_reset_ok;

    assign mode_sd      = ~s_mode;
    assign man_reset_ok = s_mreset & (s_press_pb == {NUM_MAN{1'b1}});
    assign man_d        = (s_armed & ~s_press_pb)
                        | (man_q & {NUM_MAN{~man_reset_ok}});
    assign mode_d       = (mode_sd & ~mode_expired)
                        | (mode_q & ~man_reset_ok);

    // =========================================================
    // Scram logic
    logic full_d;
    logic full_q;
    logic [NUM_MAN-1:0] load_d;

    // Two of four divisions; no bypass term at this level
    assign full_d = ptv_vote(div_trip_q)
                  | (man_q == {NUM_MAN{1'b1}}) | mode_q;
    assign load_d = {NUM_MAN{full_d}} | man_q;

    // =========================================================
    // Ten second timers
    ptv_delay_timer #(.TICKS(HOLD_CNT)) u_mode_timer (
        .clk_i     (sys_clk_i),
        .rst_b_i   (rst_b),
        .tick_i    (tick_q),
        .start_i   (mode_sd & ~mode_sd_q),
        .clear_i   (~mode_sd),
        .busy_o    (),
        .expired_o (mode_expired)
    );

    // Started on every onset of a full scram
    ptv_delay_timer #(.TICKS(HOLD_CNT)) u_inhibit_timer (
        .clk_i     (sys_clk_i),
        .rst_b_i   (rst_b),
        .tick_i    (tick_q),
        .start_i   (full_d & ~full_q),
        .clear_i   (1'b0),
        .busy_o    (inhibit_busy),
        .expired_o ()
    );

    // =========================================================
    // Latches and state
    always_ff @(posedge sys_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bypass_q   <= '0;
            div_trip_q <= '0;
            man_q      <= '0;
            mode_q     <= 1'b0;
            mode_sd_q  <= 1'b0;
            full_q     <= 1'b0;
        end
        else
        begin
            bypass_q   <= bypass_d;
            div_trip_q <= div_trip_d;
            man_q      <= man_d;
            mode_q     <= mode_d;
            mode_sd_q  <= mode_sd;
            full_q     <= full_d;
        end
    end

    // =========================================================
    // Output flops, trip drives active low
    always_ff @(posedge sys_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_trip_n_o      <= '1;
            load_div_trip_n_o <= '1;
            scram_n_o         <= 1'b1;
            chan_bypassed_o   <= '0;
            reset_inhibit_o   <= 1'b0;
            mode_bypassed_o   <= 1'b0;
        end
        else
        begin
            div_trip_n_o      <= ~div_trip_q;
            load_div_trip_n_o <= ~load_d;
            scram_n_o         <= ~full_d;
            chan_bypassed_o   <= bypass_q;
            reset_inhibit_o   <= inhibit_busy;
            mode_bypassed_o   <= mode_expired;
        end
    end

endmodule // ptv_trip_voter

// [sim/ptv_partner.sv]
// Channel comparator bank model facing the voter inputs.
// Assumes the bench commands each condition as an active-high bit.
module ptv_partner (
    // Commanded conditions, four channel bits a field
    input  wire logic [59:0] trip_i,
    // Comparator lines to the voter
    output logic      [59:0] line_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================
    // Lines idle high, so a lost line reads as a trip
    assign line_n_o = ~trip_i;
endmodule // ptv_partner

// [sim/ptv_checker_assertions.sv]
// Concurrent checks on the trip voter ports.
// Assumes one clock domain and an input-to-output latency of 3 to 6 cycles.
module ptv_checker
    import ptv_pkg::*;
(
    // Clock, reset and inputs
    input wire logic               sys_clk_i,
    input wire logic               rst_b_i,
    input wire logic [NUM_CH-1:0]  press_hi_n_i,
    input wire logic [NUM_CH-1:0]  chan_bypass_req_i,
    input wire logic [NUM_MAN-1:0] man_armed_i,
    input wire logic [NUM_MAN-1:0] man_press_n_i,
    input wire logic               mode_shutdown_n_i,
    input wire logic [NUM_DIV-1:0] div_reset_i,
    // Outputs watched
    input wire logic [NUM_DIV-1:0] div_trip_n_o,
    input wire logic [NUM_MAN-1:0] load_div_trip_n_o,
    input wire logic               scram_n_o,
    input wire logic [NUM_CH-1:0]  chan_bypassed_o,
    input wire logic               reset_inhibit_o,
    input wire logic               mode_bypassed_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // =========================================
    // Voting, scram and bypass
    chk_vote_press: assert property (
        chan_bypassed_o == 4'h0 && $countones(~press_hi_n_i) >= 2 |-> ##[1:6] div_trip_n_o == 4'h0)
        else $error("pressure vote did not trip all divisions");
    chk_scram_vote: assert property (
        $countones(~div_trip_n_o) >= 2 |-> ##[0:3] !scram_n_o)
        else $error("two tripped divisions gave no scram");
    chk_bypass_excl: assert property ($countones(chan_bypassed_o) <= 1)
        else $error("two channels bypassed at once");
    chk_bypass_grant: assert property (
        (chan_bypass_req_i == 4'h1) [*8] |-> chan_bypassed_o == 4'h1)
        else $error("lone bypass request not granted");
    // =========================================
    // Manual scram, mode switch and resets
    chk_half_scram: assert property (
        (man_armed_i == 2'h3 && man_press_n_i == 2'h2) [*6] |-> !load_div_trip_n_o[0])
        else $error("armed press gave no half scram");
    chk_reset_pressed: assert property (
        !man_press_n_i[0] && !load_div_trip_n_o[0] |=> !load_div_trip_n_o[0])
        else $error("manual latch cleared while pressed");
    chk_mode_scram: assert property ($fell(mode_shutdown_n_i) |-> ##[2:8] !scram_n_o)
        else $error("mode shutdown gave no scram");
    chk_div_seal: assert property (
        $rose(div_trip_n_o[0]) |-> $past(div_reset_i[0], 3) || $past(div_reset_i[0], 4)
        || $past(div_reset_i[0], 5))
        else $error("division trip cleared without reset");
    chk_inhibit_start: assert property ($fell(scram_n_o) |-> ##[0:2] reset_inhibit_o)
        else $error("full scram did not inhibit reset");
    chk_inhibit_hold: assert property (
        reset_inhibit_o && !div_trip_n_o[0] |=> !div_trip_n_o[0])
        else $error("division reset taken during inhibit");
    // Main scenarios reached
    cover property (!scram_n_o);
    cover property (chan_bypassed_o != 4'h0);
    cover property (load_div_trip_n_o == 2'h2);
    cover property (mode_bypassed_o);
endmodule // ptv_checker

bind ptv_trip_voter ptv_checker i_ptv_checker (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .press_hi_n_i(press_hi_n_i),
    .chan_bypass_req_i(chan_bypass_req_i), .man_armed_i(man_armed_i),
    .man_press_n_i(man_press_n_i), .mode_shutdown_n_i(mode_shutdown_n_i),
    .div_reset_i(div_reset_i), .div_trip_n_o(div_trip_n_o),
    .load_div_trip_n_o(load_div_trip_n_o), .scram_n_o(scram_n_o),
    .chan_bypassed_o(chan_bypassed_o), .reset_inhibit_o(reset_inhibit_o),
    .mode_bypassed_o(mode_bypassed_o)
);

// [sim/tb_ptv_trip_voter.sv]
// Testbench for the trip voter: comparator lines through the partner, switches direct.
// Assumes shortened counts: a tick every 4 cycles, hold of 3 ticks.
module tb_ptv_trip_voter
    import ptv_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TICKS = 4;
    localparam int unsigned HOLDS = 3;
    logic        sys_clk_i;
    logic        rst_b_i;
    logic [59:0] trip;
    logic [59:0] ln;
    logic [3:0]  fs_byp, byp_req, chg_byp, dman_n, drst, dtrip_n, bypd;
    logic [1:0]  armed, press_n, load_n;
    logic        mode_n, man_rst, scram_n, inhib, mode_byp;
    int          errors, tests_run;
    // =========================================
    // Partner and design
    ptv_partner i_ptv_partner (.trip_i(trip), .line_n_o(ln));
    ptv_trip_voter #(.TICK_CNT(TICKS), .HOLD_CNT(HOLDS)) i_ptv_trip_voter (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .press_hi_n_i(ln[3:0]),
        .level_lo_n_i(ln[7:4]), .drywell_hi_n_i(ln[11:8]), .radiation_hi_n_i(ln[15:12]),
        .seis_bot_hor_n_i(ln[19:16]), .seis_bot_ver_n_i(ln[23:20]),
        .seis_top_hor_n_i(ln[27:24]), .stop_valve_n_i(ln[31:28]),
        .fast_solenoid_n_i(ln[35:32]), .trip_oil_lo_n_i(ln[39:36]),
        .charging_lo_n_i(ln[43:40]), .iso_inboard_n_i(ln[47:44]),
        .iso_outboard_n_i(ln[51:48]), .source_range_trip_n_i(ln[55:52]),
        .power_range_trip_n_i(ln[59:56]), .first_stage_byp_i(fs_byp),
        .chan_bypass_req_i(byp_req), .charging_bypass_i(chg_byp), .man_armed_i(armed),
        .man_press_n_i(press_n), .mode_shutdown_n_i(mode_n), .div_man_trip_n_i(dman_n),
        .man_reset_i(man_rst), .div_reset_i(drst), .div_trip_n_o(dtrip_n),
        .load_div_trip_n_o(load_n), .scram_n_o(scram_n), .chan_bypassed_o(bypd),
        .reset_inhibit_o(inhib), .mode_bypassed_o(mode_byp)
    );
    // =========================================
    // Clock and shared tasks
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Bounded wait for the reset inhibit to lapse, then a held division reset
    task automatic clear_div(input logic [3:0] which);
        int n;
        n = 0;
        while (inhib !== 1'b0)
        begin
            step(1);
            n++;
            if (n > 500)
            begin
                errors++;
                summarize();
            end
        end
        drst <= which;
        step(10);
        drst <= 4'h0;
        step(6);
    endtask
    // =========================================
    // Main sequence
    initial
    begin
        errors = 0;
        tests_run = 0;
        rst_b_i = 1'b0;
        trip = '0;
        {fs_byp, byp_req, chg_byp, drst} = '0;
        dman_n = 4'hF;
        armed = 2'h0;
        press_n = 2'h3;
        {mode_n, man_rst} = 2'h2;
        step(20);
        rst_b_i <= 1'b1;
        step(8);
        chk("idle", {dtrip_n, load_n, scram_n, inhib}, 8'hFE);
        $display("Test idle done");
        for (int k = 0; k < 15; k++)
        begin
            if (k == 10)
                continue;
            trip <= 60'h1 << (4 * k);
            step(8);
            chk("single", {4'h0, dtrip_n}, 8'h0F);
            trip <= 60'h3 << (4 * k);
            step(8);
            chk("vote", {2'h0, inhib, scram_n, dtrip_n}, 8'h20);
            chk("vote divisions", {4'h0, dtrip_n}, 8'h00);
            trip <= '0;
            step(4);
            clear_div(4'hF);
            chk("cleared", {3'h0, scram_n, dtrip_n}, 8'h1F);
        end
        $display("Test votes done");
        fs_byp <= 4'hF;
        trip <= 60'h3 << 28;
        step(8);
        chk("first stage", {4'h0, dtrip_n}, 8'h0F);
        fs_byp <= 4'h0;
        step(8);
        clear_div(4'hF);
        chk("held cause", {4'h0, dtrip_n}, 8'h00);
        trip <= '0;
        byp_req <= 4'h1;
        step(8);
        clear_div(4'hF);
        byp_req <= 4'h3;
        step(8);
        chk("bypass", {4'h0, bypd}, 8'h01);
        trip <= 60'h3;
        step(8);
        chk("masked", {4'h0, dtrip_n}, 8'h0F);
        trip <= 60'h7;
        step(8);
        chk("two of three", {4'h0, dtrip_n}, 8'h00);
        trip <= '0;
        byp_req <= 4'h0;
        step(8);
        clear_div(4'hF);
        $display("Test bypass done");
        trip <= 60'h3 << 40;
        step(8);
        clear_div(4'hF);
        chk("charging held", {4'h0, dtrip_n}, 8'h00);
        chg_byp <= 4'hF;
        step(4);
        clear_div(4'hF);
        chk("charging bypassed", {4'h0, dtrip_n}, 8'h0F);
        trip <= '0;
        chg_byp <= 4'h0;
        armed <= 2'h3;
        press_n <= 2'h2;
        step(8);
        chk("half", {5'h0, scram_n, load_n}, 8'h06);
        man_rst <= 1'b1;
        step(8);
        chk("reset pressed", {5'h0, scram_n, load_n}, 8'h06);
        press_n <= 2'h3;
        step(8);
        chk("reset", {5'h0, scram_n, load_n}, 8'h07);
        man_rst <= 1'b0;
        press_n <= 2'h0;
        step(8);
        chk("full", {5'h0, scram_n, load_n}, 8'h00);
        press_n <= 2'h3;
        man_rst <= 1'b1;
        step(8);
        man_rst <= 1'b0;
        chk("manual clear", {5'h0, scram_n, load_n}, 8'h07);
        mode_n <= 1'b0;
        step(8);
        chk("mode scram", {7'h0, scram_n}, 8'h00);
        step(HOLDS * TICKS + 10);
        chk("mode timed", {7'h0, mode_byp}, 8'h01);
        man_rst <= 1'b1;
        step(8);
        man_rst <= 1'b0;
        chk("mode cleared", {7'h0, scram_n}, 8'h01);
        mode_n <= 1'b1;
        $display("Test manual done");
        clear_div(4'h0);
        dman_n <= 4'hB;
        step(8);
        chk("div manual", {3'h0, scram_n, dtrip_n}, 8'h1B);
        chk("no inhibit", {7'h0, inhib}, 8'h00);
        dman_n <= 4'hF;
        step(4);
        drst <= 4'h4;
        step(8);
        drst <= 4'h0;
        chk("div reset", {3'h0, scram_n, dtrip_n}, 8'h1F);
        dman_n <= 4'hC;
        step(8);
        chk("two manual", {3'h0, scram_n, dtrip_n}, 8'h0C);
        $display("Test division done");
        summarize();
    end
endmodule // tb_ptv_trip_voter
